// >>> hw/acs_pkg.sv
package acs_pkg;
    // ***********************************
    // Sequencing and timing constants
    // ***********************************
    localparam int         HALF_W       = 6;
    localparam int         RESULT_W     = 12;
    localparam int         PHASE_W      = 3;
    localparam int         AGE_W        = 4;
    localparam int         CNT_W        = 18;
    localparam int         SETTLE_W     = 13;
    localparam logic [2:0] PHASE_FIRST  = 3'h0;
    localparam logic [2:0] PHASE_LAST   = 3'h7;
    localparam logic [3:0] CONV_CONT    = 4'ha;
    localparam logic [3:0] CONV_EARLY   = 4'hb;
    localparam logic [3:0] CONV_LATE    = 4'ha;
    localparam logic [3:0] AGE_START    = 4'h1;
    localparam logic [3:0] AGE_FLASH1   = 4'h2;
    localparam logic [3:0] AGE_RES_ON   = 4'h3;
    localparam logic [3:0] AGE_TRACK    = 4'h4;
    localparam logic [3:0] AGE_FLASH2   = 4'h6;
    localparam logic [1:0] RDY_CYCLES   = 2'h3;
    localparam int         CAL_CYCLES   = 203578;
    localparam int         SETTLE_CYCLES = 4288;
    localparam logic [3:0] RST_LOW      = 4'h2;
    localparam logic [3:0] CAL_PULSE    = 4'h2;
    localparam logic [2:0] HOLD_LOW     = 3'h4;

    // ***********************************
    // Device sequencing modes
    // ***********************************
    typedef enum logic [4:0] {
        ST_UNCAL = 5'h01,
        ST_CLEAR = 5'h02,
        ST_CAL   = 5'h04,
        ST_FIRST = 5'h08,
        ST_RUN   = 5'h10
    } acs_mode_t;
endpackage : acs_pkg

// >>> hw/acs_link_if.sv
`timescale 1ns/1ps
interface acs_link_if;
    // ***********************************
    // Pins between controller and converter
    // ***********************************
    logic sample_hold_n;
    logic continuous_mode_sel;
    logic hw_reset_n;
    logic calibrate_strobe;
    logic chip_select_n;
    logic result_ready_n;

    modport dev (
        input  sample_hold_n,
        input  continuous_mode_sel,
        input  hw_reset_n,
        input  calibrate_strobe,
        input  chip_select_n,
        output result_ready_n
    );

    modport host (
        output sample_hold_n,
        output continuous_mode_sel,
        output hw_reset_n,
        output calibrate_strobe,
        output chip_select_n,
        input  result_ready_n
    );
endinterface : acs_link_if

// >>> hw/acs_device.sv
// How it works
// RL1: Continuous mode self-holds every eight clocks
// RL2: Hold falling edge starts conversion next edge
// RL3: Controller spaces holds at multiples of eight
// RL4: First hold after calibration sets phase zero
// RL5: Later holds land between state 7 and 0
// RL6: Misplaced hold restarts 4288-cycle adjustment
// RL7: Results untrusted 4288 cycles after first hold
// RL8: Continuous mode: one result per eight, latency ten
// RL9: External holds convert in 10 or 11 cycles
// RL10: Conversions overlap two to three cycles
// RL11: Next hold accepted before previous result
// RL12: Upper six bits, then residue times 64
// RL13: Master clock never stopped over one second
// RL14: Clock cycles may be skipped, average held
// RL15: Reset or calibrate after power-up, anytime later
// RL16: Consumer may decimate results for lower rates
// RL17: Ready low three clocks per new result
// RL18: Reset clears; release starts 203,578-cycle calibration
// RL19: Calibrate strobe with select low calibrates
// RL20: Reset overrides all, restarts calibration
// RL21: Free modulo-eight phase checks hold window
`timescale 1ns/1ps
module acs_device #(
    parameter int CAL_CYCLES    = acs_pkg::CAL_CYCLES,
    parameter int SETTLE_CYCLES = acs_pkg::SETTLE_CYCLES
) (
    input  wire logic                          clock_i,
    input  wire logic                          resetn_i,
    acs_link_if.dev                            link,
    input  wire logic [acs_pkg::HALF_W-1:0]    flash_code_i,
    output logic      [acs_pkg::RESULT_W-1:0]  result_o,
    output logic                               result_strobe_o,
    output logic                               front_hold_o,
    output logic                               residue_hold_o,
    output logic                               calibrating_o,
    output logic                               accurate_o,
    output logic                               window_error_o,
    output logic      [acs_pkg::PHASE_W-1:0]   phase_o
);
    // ***********************************
    // State
    // ***********************************
    typedef struct packed {
        acs_pkg::acs_mode_t                        mode;
        logic [acs_pkg::CNT_W-1:0]                 cal_cnt;
        logic [acs_pkg::SETTLE_W-1:0]              settle_cnt;
        logic                                      accurate;
        logic                                      calib;
        logic [acs_pkg::PHASE_W-1:0]               phase;
        logic                                      hold_n_d;
        logic [1:0]                                act;
        logic [1:0][acs_pkg::AGE_W-1:0]            age;
        logic [1:0][acs_pkg::AGE_W-1:0]            len;
        logic [1:0][acs_pkg::HALF_W-1:0]           coarse;
        logic [1:0][acs_pkg::HALF_W-1:0]           fine;
        logic [acs_pkg::RESULT_W-1:0]              result;
        logic                                      strobe;
        logic [1:0]                                rdy_cnt;
        logic                                      rdy_n;
        logic                                      front_hold;
        logic                                      res_hold;
        logic                                      win_err;
    } acs_dev_state_t;

    localparam logic [acs_pkg::CNT_W-1:0]    CAL_LOAD    = acs_pkg::CNT_W'(CAL_CYCLES);
    localparam logic [acs_pkg::SETTLE_W-1:0] SETTLE_LOAD = acs_pkg::SETTLE_W'(SETTLE_CYCLES);

    acs_dev_state_t q;
    acs_dev_state_t next_q;

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        logic                       ext_fall;
        logic                       int_hold;
        logic                       hold;
        logic                       cal_req;
        logic                       in_window;
        logic                       slot;
        logic                       fh;
        logic                       rh;
        logic [acs_pkg::AGE_W-1:0]  nage;
        logic [acs_pkg::AGE_W-1:0]  conv_len;
        ext_fall  = 1'b0;
        int_hold  = 1'b0;
        hold      = 1'b0;
        cal_req   = 1'b0;
        in_window = 1'b0;
        slot      = 1'b0;
        fh        = 1'b0;
        rh        = 1'b0;
        nage      = '0;
        conv_len  = '0;
        next_q          = q;
        next_q.strobe   = 1'b0;
        next_q.win_err  = 1'b0;
        next_q.hold_n_d = link.sample_hold_n;
        next_q.phase    = q.phase + 3'h1; // RL21
        ext_fall = q.hold_n_d & ~link.sample_hold_n; // RL2
        int_hold = link.continuous_mode_sel & link.sample_hold_n & (q.phase == acs_pkg::PHASE_LAST); // RL1
        hold     = (q.mode == acs_pkg::ST_FIRST || q.mode == acs_pkg::ST_RUN) & (ext_fall | int_hold);
        in_window = (q.phase == acs_pkg::PHASE_LAST) || (q.phase == acs_pkg::PHASE_FIRST); // RL21
        cal_req  = link.calibrate_strobe & ~link.chip_select_n; // RL19

        // Fixed-phase completion: an early hold converts one cycle longer
        if (link.continuous_mode_sel && link.sample_hold_n) begin
            conv_len = acs_pkg::CONV_CONT; // RL8
        end else if (q.mode == acs_pkg::ST_RUN && q.phase == acs_pkg::PHASE_LAST) begin
            conv_len = acs_pkg::CONV_EARLY; // RL9
        end else begin
            conv_len = acs_pkg::CONV_LATE; // RL9
        end

        // Conversion slots: two in flight cover the 2-3 cycle overlap
        for (int i = 0; i < 2; i++) begin
            nage = q.age[i] + 4'h1;
            if (q.act[i]) begin
                next_q.age[i] = nage;
                if (nage < acs_pkg::AGE_TRACK) begin
                    fh = 1'b1; // RL11
                end
                if (nage >= acs_pkg::AGE_RES_ON && nage <= acs_pkg::AGE_FLASH2) begin
                    rh = 1'b1; // RL11
                end
                if (nage == acs_pkg::AGE_FLASH1) begin
                    next_q.coarse[i] = flash_code_i; // RL12
                end
                if (nage == acs_pkg::AGE_FLASH2) begin
                    next_q.fine[i] = flash_code_i; // RL12
                end
                if (nage == q.len[i]) begin
                    next_q.act[i]  = 1'b0;
                    next_q.result  = {q.coarse[i], {acs_pkg::HALF_W{1'b0}}} | // RL12
                                     {{acs_pkg::HALF_W{1'b0}}, q.fine[i]};
                    next_q.strobe  = 1'b1;
                    next_q.rdy_n   = 1'b0; // RL17
                    next_q.rdy_cnt = acs_pkg::RDY_CYCLES; // RL17
                end
            end
        end

        // Ready pulse countdown
        if (q.rdy_cnt != 2'h0 && next_q.rdy_cnt == q.rdy_cnt) begin
            next_q.rdy_cnt = q.rdy_cnt - 2'h1;
            if (q.rdy_cnt == 2'h1) begin
                next_q.rdy_n = 1'b1; // RL17
            end
        end

        // Background adjustment settle time
        if (q.settle_cnt != '0) begin
            next_q.settle_cnt = q.settle_cnt - 13'h1;
            if (q.settle_cnt == 13'h1) begin
                next_q.accurate = 1'b1; // RL6
            end
        end

        // New hold takes a free slot while the older one finishes
        if (hold) begin
            slot = q.act[0];
            if (!(q.act[0] && q.act[1])) begin
                next_q.act[slot] = 1'b1; // RL10
                next_q.age[slot] = acs_pkg::AGE_START; // RL2
                next_q.len[slot] = conv_len;
                fh = 1'b1; // RL2
            end
            if (q.mode == acs_pkg::ST_FIRST) begin
                next_q.mode       = acs_pkg::ST_RUN;
                next_q.phase      = acs_pkg::PHASE_FIRST; // RL4
                next_q.settle_cnt = SETTLE_LOAD; // RL6
                next_q.accurate   = 1'b0;
            end else if (!in_window) begin
                next_q.win_err    = 1'b1; // RL6
                next_q.settle_cnt = SETTLE_LOAD; // RL6
                next_q.accurate   = 1'b0; // RL6
            end
        end
        next_q.front_hold = fh;
        next_q.res_hold   = rh;

        // Calibration sequencing
        unique case (q.mode)
            acs_pkg::ST_UNCAL, acs_pkg::ST_CLEAR: begin
                if (q.mode == acs_pkg::ST_CLEAR && link.hw_reset_n && !cal_req) begin
                    next_q.mode    = acs_pkg::ST_CAL; // RL18
                    next_q.cal_cnt = CAL_LOAD; // RL18
                end
            end
            acs_pkg::ST_CAL: begin
                next_q.cal_cnt = q.cal_cnt - 18'h1;
                if (q.cal_cnt == 18'h1) begin
                    next_q.mode = acs_pkg::ST_FIRST; // RL4
                end
            end
            acs_pkg::ST_FIRST, acs_pkg::ST_RUN: begin
            end
        endcase

        // Reset and calibrate are level sensitive and win over everything
        if (!link.hw_reset_n || cal_req) begin
            next_q            = '0; // RL20
            next_q.mode       = acs_pkg::ST_CLEAR; // RL15
            next_q.hold_n_d   = link.sample_hold_n;
            next_q.rdy_n      = 1'b1;
        end
        next_q.calib = (next_q.mode == acs_pkg::ST_CAL) || (next_q.mode == acs_pkg::ST_CLEAR);
    end

    // ***********************************
    // Register
    // ***********************************
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q          <= '0;
            q.mode     <= acs_pkg::ST_UNCAL;
            q.hold_n_d <= 1'b1;
            q.rdy_n    <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign link.result_ready_n = q.rdy_n;
    assign result_o            = q.result;
    assign result_strobe_o     = q.strobe;
    assign front_hold_o        = q.front_hold;
    assign residue_hold_o      = q.res_hold;
    assign calibrating_o       = q.calib;
    assign accurate_o          = q.accurate;
    assign window_error_o      = q.win_err;
    assign phase_o             = q.phase;
endmodule : acs_device

// >>> hw/acs_host.sv
`timescale 1ns/1ps
module acs_host #(
    parameter int CAL_CYCLES    = acs_pkg::CAL_CYCLES,
    parameter int SETTLE_CYCLES = acs_pkg::SETTLE_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    acs_link_if.host         link,
    input  wire logic        run_i,
    input  wire logic        cont_mode_i,
    input  wire logic        reset_req_i,
    input  wire logic        cal_req_i,
    input  wire logic [3:0]  interval_i,
    input  wire logic [7:0]  decim_i,
    output logic             ready_o,
    output logic             sample_o,
    output logic             trusted_o
);
    // ***********************************
    // State
    // ***********************************
    typedef struct packed {
        logic                          hold_n;
        logic                          cont;
        logic                          rst_n;
        logic                          cal;
        logic [3:0]                    pulse;
        logic [acs_pkg::CNT_W-1:0]     wait_cnt;
        logic                          ready;
        logic [2:0]                    phase;
        logic [3:0]                    mult;
        logic                          first;
        logic [acs_pkg::SETTLE_W-1:0]  settle;
        logic                          trusted;
        logic                          rdy_d;
        logic [7:0]                    dec_cnt;
        logic                          sample;
    } acs_host_state_t;

    localparam logic [acs_pkg::CNT_W-1:0]    CAL_LOAD    = acs_pkg::CNT_W'(CAL_CYCLES);
    localparam logic [acs_pkg::SETTLE_W-1:0] SETTLE_LOAD = acs_pkg::SETTLE_W'(SETTLE_CYCLES);

    acs_host_state_t q;
    acs_host_state_t next_q;

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        logic issue;
        issue         = 1'b0;
        next_q        = q;
        next_q.sample = 1'b0;
        next_q.cont   = cont_mode_i;
        next_q.phase  = q.phase + 3'h1;

        // Pulse widths of two cycles, at the lower end of the 2..4096 cycle limits
        if (q.pulse != 4'h0) begin
            next_q.pulse = q.pulse - 4'h1;
            if (q.pulse == 4'h1) begin
                next_q.rst_n = 1'b1;
                next_q.cal   = 1'b0;
            end
        end else if (reset_req_i || cal_req_i) begin
            next_q.rst_n    = ~reset_req_i; // RL15
            next_q.cal      = ~reset_req_i; // RL15
            next_q.pulse    = reset_req_i ? acs_pkg::RST_LOW : acs_pkg::CAL_PULSE;
            next_q.wait_cnt = CAL_LOAD;
            next_q.ready    = 1'b0;
            next_q.first    = 1'b1;
            next_q.trusted  = 1'b0;
            next_q.settle   = '0;
            next_q.hold_n   = 1'b1;
        end else if (!q.ready && q.wait_cnt != '0) begin
            next_q.wait_cnt = q.wait_cnt - 18'h1;
            next_q.ready    = (q.wait_cnt == 18'h1);
        end

        // Holds only on the eight-clock grid, interval_i+1 grid periods apart
        if (q.phase == acs_pkg::PHASE_LAST) begin
            next_q.mult = (q.mult >= interval_i) ? 4'h0 : q.mult + 4'h1; // RL3
        end
        issue = q.ready && q.pulse == 4'h0 && run_i && !cont_mode_i &&
                q.phase == acs_pkg::PHASE_FIRST && q.mult == 4'h0; // RL5
        if (issue) begin
            next_q.hold_n = 1'b0; // RL3
            if (q.first) begin
                next_q.first  = 1'b0;
                next_q.settle = SETTLE_LOAD; // RL7
            end
        end else if (q.phase == acs_pkg::HOLD_LOW) begin
            next_q.hold_n = 1'b1;
        end
        if (cont_mode_i && q.ready && q.first && q.phase == acs_pkg::PHASE_LAST) begin
            next_q.first  = 1'b0;
            next_q.settle = SETTLE_LOAD; // RL7
        end

        if (q.settle != '0) begin
            next_q.settle  = q.settle - 13'h1;
            next_q.trusted = (q.settle == 13'h1); // RL7
        end

        // Ready falling edge, every decim_i+1 one kept
        next_q.rdy_d = link.result_ready_n;
        if (q.rdy_d && !link.result_ready_n) begin
            if (q.dec_cnt >= decim_i) begin
                next_q.dec_cnt = 8'h0;
                next_q.sample  = 1'b1; // RL16
            end else begin
                next_q.dec_cnt = q.dec_cnt + 8'h1;
            end
        end
    end

    // ***********************************
    // Register
    // ***********************************
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q        <= '0;
            q.hold_n <= 1'b1;
            q.rst_n  <= 1'b1;
            q.rdy_d  <= 1'b1;
            q.first  <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign link.sample_hold_n       = q.hold_n;
    assign link.continuous_mode_sel = q.cont;
    assign link.hw_reset_n          = q.rst_n;
    assign link.calibrate_strobe    = q.cal;
    assign link.chip_select_n       = ~q.cal;
    assign ready_o                  = q.ready;
    assign sample_o                 = q.sample;
    assign trusted_o                = q.trusted;
endmodule : acs_host

// >>> tb/acs_chk.sv
`timescale 1ns/1ps
module acs_chk #(
    parameter int CAL_CYCLES = 40
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sample_hold_n,
    input wire logic continuous_mode_sel,
    input wire logic hw_reset_n,
    input wire logic calibrate_strobe,
    input wire logic chip_select_n,
    input wire logic result_ready_n
);
    // ****
    // Helpers
    // ****
    logic        clr;
    logic        caled;
    logic        shn_q;
    logic        seen;
    logic [2:0]  gap;
    logic [4:0]  cont_run;
    logic [17:0] quiet;
    assign clr = !hw_reset_n || (calibrate_strobe && !chip_select_n);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            caled    <= 1'b0;
            shn_q    <= 1'b1;
            seen     <= 1'b0;
            gap      <= 3'h0;
            cont_run <= 5'h00;
            quiet    <= 18'h00000;
        end else begin
            shn_q    <= sample_hold_n;
            gap      <= (shn_q && !sample_hold_n) ? 3'h1 : gap + 3'h1;
            seen     <= !clr && (seen || (shn_q && !sample_hold_n));
            caled    <= caled || clr;
            cont_run <= (clr || !continuous_mode_sel || !sample_hold_n) ? 5'h00 :
                        (cont_run == 5'h1f) ? cont_run : cont_run + 5'h01;
            // Saturates so a long run cannot wrap back into the quiet zone
            quiet    <= clr ? 18'h00000 : (int'(quiet) > CAL_CYCLES + 3) ? quiet : quiet + 18'h00001;
        end
    end
    // ****
    // Link rules
    // ****
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    a_ready_three_low: assert property (disable iff (!resetn_i || clr)
        $fell(result_ready_n) |-> (!result_ready_n)[*3] ##1 result_ready_n)
        else $error("ready pulse width wrong");
    a_hold_latency: assert property (disable iff (!resetn_i || clr)
        $fell(sample_hold_n) && !continuous_mode_sel && caled && int'(quiet) > CAL_CYCLES + 3
        |-> ##[10:11] $fell(result_ready_n))
        else $error("hold to ready latency wrong");
    a_cont_period: assert property (disable iff (!resetn_i || clr)
        $fell(result_ready_n) && cont_run == 5'h1f |-> ##8 $fell(result_ready_n))
        else $error("continuous result period wrong");
    a_reset_clears: assert property (clr |=> result_ready_n)
        else $error("ready not cleared by reset");
    a_cal_quiet: assert property (disable iff (!resetn_i || clr)
        int'(quiet) <= CAL_CYCLES |-> result_ready_n)
        else $error("result during calibration");
    a_hold_spacing: assert property ($fell(sample_hold_n) && seen |-> gap == 3'h0)
        else $error("hold spacing not a multiple of eight");
    a_hold_width: assert property ($fell(sample_hold_n) |-> (!sample_hold_n)[*4] ##1 sample_hold_n)
        else $error("hold low width wrong");
    a_select_with_cal: assert property (calibrate_strobe != chip_select_n)
        else $error("select does not track calibrate");
    a_cal_pulse_width: assert property ($rose(calibrate_strobe) |-> calibrate_strobe[*2] ##1 !calibrate_strobe)
        else $error("calibrate pulse width wrong");
    a_rst_pulse_width: assert property ($fell(hw_reset_n) |-> (!hw_reset_n)[*2] ##1 hw_reset_n)
        else $error("reset pulse width wrong");
    c_ext_hold: cover property ($fell(sample_hold_n) && !continuous_mode_sel && caled);
    c_cont: cover property ($fell(result_ready_n) && cont_run == 5'h1f);
    c_cal: cover property ($rose(calibrate_strobe));
endmodule : acs_chk

// >>> tb/tb_adc_conversion_sequencer.sv
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
    // ****
    // Signals
    // ****
    localparam int         CAL = 40;
    localparam int         SET = 30;
    localparam logic [5:0] HI  = 6'h2d;
    localparam logic [5:0] LO  = 6'h13;
    logic        clock_i    = 1'b0;
    logic        resetn_i   = 1'b0;
    logic        run        = 1'b0;
    logic        cont_mode  = 1'b0;
    logic        reset_req  = 1'b0;
    logic        cal_req    = 1'b0;
    logic [3:0]  interval   = 4'h0;
    logic [7:0]  decim      = 8'h00;
    logic [5:0]  flash_code = 6'h00;
    logic        werr_seen  = 1'b0;
    logic [11:0] result;
    logic [2:0]  phase, phase2;
    logic        strobe, front_hold, residue_hold, calibrating, accurate, werr;
    logic        ready, sample, trusted, accurate2, werr2;
    int          failures   = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    acs_link_if link();
    acs_link_if link2();
    acs_device #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(SET)) acs_device_i (
        .clock_i(clock_i), .resetn_i(resetn_i), .link(link.dev), .flash_code_i(flash_code),
        .result_o(result), .result_strobe_o(strobe), .front_hold_o(front_hold),
        .residue_hold_o(residue_hold), .calibrating_o(calibrating), .accurate_o(accurate),
        .window_error_o(werr), .phase_o(phase));
    // Second end faces a bench driver that misplaces holds on purpose
    acs_device #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(SET)) acs_device_x_i (
        .clock_i(clock_i), .resetn_i(resetn_i), .link(link2.dev), .flash_code_i(6'h00),
        .result_o(), .result_strobe_o(), .front_hold_o(), .residue_hold_o(), .calibrating_o(),
        .accurate_o(accurate2), .window_error_o(werr2), .phase_o(phase2));
    acs_host #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(SET)) acs_host_i (
        .clock_i(clock_i), .resetn_i(resetn_i), .link(link.host), .run_i(run),
        .cont_mode_i(cont_mode), .reset_req_i(reset_req), .cal_req_i(cal_req),
        .interval_i(interval), .decim_i(decim), .ready_o(ready), .sample_o(sample),
        .trusted_o(trusted));
    acs_chk #(.CAL_CYCLES(CAL)) acs_chk_i (
        .clock_i(clock_i), .resetn_i(resetn_i), .sample_hold_n(link.sample_hold_n),
        .continuous_mode_sel(link.continuous_mode_sel), .hw_reset_n(link.hw_reset_n),
        .calibrate_strobe(link.calibrate_strobe), .chip_select_n(link.chip_select_n),
        .result_ready_n(link.result_ready_n));
    // ****
    // Clock, flash source, watchdog
    // ****
    always #25 clock_i = ~clock_i;
    // Upper code until the residue tracker holds, lower code after
    always @(negedge clock_i) flash_code <= residue_hold ? LO : HI;
    always @(posedge clock_i) begin
        cycles++;
        if (werr2 === 1'b1) werr_seen <= 1'b1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic print_verdict;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    function automatic logic pick(input int which);
        case (which)
            0: return strobe;
            1: return sample;
            default: return ready;
        endcase
    endfunction : pick
    task automatic wait_ev(input int which, output int cyc);
        cyc = 0;
        do begin
            @(negedge clock_i);
            cyc++;
        end while (pick(which) !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) begin
            failures++;
            print_verdict();
        end
    endtask : wait_ev
    task automatic t_calib(input logic use_cal);
        int c;
        reset_req = !use_cal;
        cal_req = use_cal;
        tick(1);
        reset_req = 1'b0;
        cal_req = 1'b0;
        tick(4);
        check(12'(calibrating), 12'h001);
        check(12'(ready), 12'h000);
        wait_ev(2, c);
        check(12'(c >= CAL - 8), 12'h001);
    endtask : t_calib
    task automatic t_external;
        int c;
        run = 1'b1;
        wait_ev(0, c);
        check(result, {HI, LO});
        check(12'(link.result_ready_n), 12'h000);
        check(12'(accurate), 12'h000);
        check(12'(front_hold), 12'h001);
        check(12'(residue_hold), 12'h000);
        // First result is short, later holds land on phase 7 and take one cycle more
        wait_ev(0, c);
        check(12'(c), 12'h009);
        wait_ev(0, c);
        check(12'(c), 12'h008);
        tick(SET);
        check(12'(accurate), 12'h001);
        check(12'(trusted), 12'h001);
    endtask : t_external
    task automatic t_decim;
        int c;
        interval = 4'h2;
        decim = 8'h01;
        wait_ev(1, c);
        wait_ev(1, c);
        wait_ev(1, c);
        check(12'(c), 12'h030);
    endtask : t_decim
    task automatic t_cont;
        int c;
        run = 1'b0;
        tick(24);
        cont_mode = 1'b1;
        wait_ev(0, c);
        wait_ev(0, c);
        check(12'(c), 12'h008);
        check(result, {HI, LO});
    endtask : t_cont
    task automatic hold2(input int pre);
        tick(pre);
        link2.sample_hold_n = 1'b0;
        tick(4);
        link2.sample_hold_n = 1'b1;
        tick(4);
    endtask : hold2
    task automatic t_window;
        link2.hw_reset_n = 1'b0;
        tick(2);
        link2.hw_reset_n = 1'b1;
        tick(CAL + 5);
        link2.sample_hold_n = 1'b0;
        tick(1);
        check(12'(phase2), 12'h000);
        tick(3);
        link2.sample_hold_n = 1'b1;
        tick(4);
        werr_seen = 1'b0;
        repeat (5) hold2(0);
        check(12'(werr_seen), 12'h000);
        check(12'(accurate2), 12'h001);
        hold2(3);
        check(12'(werr_seen), 12'h001);
        check(12'(accurate2), 12'h000);
    endtask : t_window
    // ****
    // Main sequence
    // ****
    initial begin
        link2.sample_hold_n = 1'b1;
        link2.continuous_mode_sel = 1'b0;
        link2.hw_reset_n = 1'b1;
        link2.calibrate_strobe = 1'b0;
        link2.chip_select_n = 1'b1;
        tick(12);
        resetn_i = 1'b1;
        t_calib(1'b0);
        t_external();
        t_decim();
        t_cont();
        t_calib(1'b1);
        t_cont();
        t_window();
        print_verdict();
    end
endmodule : tb_adc_conversion_sequencer
